// ==== core/ghap_port.sv ====
// Host access port core: latches host address, paces host strobes, drives latch strobes,
// ready and host interrupt. Assumes an internal access engine answers o_acc_req with
// i_acc_done, and that host control register logic supplies the halt clear and request bit.
`timescale 1ns/1ps

// Contract
// [RQ1] Host presents a long-word address on 27 inputs mapping to local bits 5..31.
// [RQ2] Host drives 4 byte selects marking active bytes of the long word.
// [RQ3] Chip select going low captures host address and byte selects.
// [RQ4] Host accesses are accepted only while chip select is low.
// [RQ5] Chip select at reset release picks halted host-present or self-bootstrap mode.
// [RQ6] On reads the latch strobe rises when local read data is ready.
// [RQ7] Host may combine latch strobe with ready to see valid read data.
// [RQ8] Host interrupt follows the interrupt-out request bit of host control.
// [RQ9] Bus fault or retry during a host access can raise the host interrupt.
// [RQ10] Write-latch output enable is asserted during host write cycles.
// [RQ11] Host may combine write-latch enable with ready to see write completion.
// [RQ12] Ready stays low by default and rises only when completion is possible.
// [RQ13] Host waits for ready high before completing its access.
// [RQ14] Host drives the read strobe low to request a read.
// [RQ15] Host drives the write strobe low to signal a pending write.
// [RQ16] Write strobe rising edge means write data sits in the external latch.
// [RQ17] Host never asserts read and write strobes together.
// [RQ18] After host-present reset the device stays halted until halt bit is cleared.
// [RQ19] All host-facing outputs change synchronously to the local clock.
// [RQ20] Captured address and byte selects stay stable for the whole access.
module ghap_port (
  input  wire logic                         i_sys_clk,
  input  wire logic                         i_rstn,
  input  wire logic [ghap_pkg::ADDR_W-1:0]  i_host_long_addr,
  input  wire logic [ghap_pkg::BSEL_W-1:0]  i_host_byte_sel,
  input  wire logic                         i_host_select_n,
  input  wire logic                         i_host_read_n,
  input  wire logic                         i_host_write_n,
  input  wire logic                         i_acc_done,
  input  wire logic                         i_bus_fault_in,
  input  wire logic                         i_retry_in,
  input  wire logic                         i_irq_out_request_bit,
  input  wire logic                         i_fault_irq_en,
  input  wire logic                         i_fault_clr,
  input  wire logic                         i_halt_clear,
  output logic                              o_host_ready_out,
  output logic                              o_read_latch_strobe,
  output logic                              o_write_latch_oe,
  output logic                              o_host_irq_out,
  output logic                              o_acc_req,
  output logic                              o_acc_we,
  output logic [ghap_pkg::ADDR_W-1:0]       o_acc_addr,
  output logic [ghap_pkg::BSEL_W-1:0]       o_acc_bsel,
  output logic                              o_fault_flag,
  output logic                              o_halted,
  output logic                              o_self_boot
);

  // All core state sits in one register so reset and next state stay in step
  typedef struct packed {
    ghap_pkg::ghap_state_t          state;
    logic                           cs_prev;
    logic                           wr_prev;
    logic [ghap_pkg::ADDR_W-1:0]    addr;
    logic [ghap_pkg::BSEL_W-1:0]    bsel;
    logic [1:0]                     strap_cnt;
    logic                           strap_done;
    logic                           halted;
    logic                           self_boot;
    logic                           fault;
    logic                           irq;
    logic                           ready;
    logic                           dstb;
    logic                           oe;
    logic                           req;
    logic                           we;
  } ghap_core_t;

  localparam ghap_core_t CORE_RST = '{
    state:      ghap_pkg::GHAP_IDLE,
    cs_prev:    ghap_pkg::STB_IDLE,
    wr_prev:    ghap_pkg::STB_IDLE,
    addr:       ghap_pkg::ADDR_RST,
    bsel:       ghap_pkg::BSEL_RST,
    strap_cnt:  2'h0,
    strap_done: 1'b0,
    halted:     1'b0,
    self_boot:  1'b0,
    fault:      1'b0,
    irq:        1'b0,
    ready:      1'b0,
    dstb:       ghap_pkg::STB_IDLE,
    oe:         1'b0,
    req:        1'b0,
    we:         1'b0
  };

  ghap_pin_if pin_bus ();

  ghap_sync u_sync (
    .i_sys_clk        (i_sys_clk),
    .i_rstn           (i_rstn),
    .i_host_select_n  (i_host_select_n),
    .i_host_read_n    (i_host_read_n),
    .i_host_write_n   (i_host_write_n),
    .i_host_long_addr (i_host_long_addr),
    .i_host_byte_sel  (i_host_byte_sel),
    .pin_out          (pin_bus.src)
  );

  ghap_pkg::ghap_pins_t p;
  ghap_core_t           q;
  ghap_core_t           d;
  logic                 abort;

  // Retry ends the access exactly like a bus fault; the host still gets ready
  assign p     = pin_bus.pins;
  assign abort = i_bus_fault_in | i_retry_in;

  always_comb begin
    d         = q;
    d.cs_prev = p.cs_n;
    d.wr_prev = p.wr_n;

    // A clear in the strap cycle loses: the strap below sets halted afterwards
    if (i_halt_clear) begin
      d.halted = 1'b0;                               // RQ18
    end
    // Strap waits for the synchroniser to fill so reset values are not mistaken for the pin
    if (!q.strap_done) begin
      if (q.strap_cnt == ghap_pkg::STRAP_WAIT) begin
        d.strap_done = 1'b1;
        d.halted     = p.cs_n;                       // RQ5
        d.self_boot  = ~p.cs_n;                      // RQ5
      end else begin
        d.strap_cnt = q.strap_cnt + 2'h1;
      end
    end

    if (i_fault_clr) begin
      d.fault = 1'b0;
    end

    case (q.state)
      ghap_pkg::GHAP_IDLE: begin
        // Latch only while idle so an access in flight keeps its address
        if (q.cs_prev && !p.cs_n) begin
          d.addr = p.addr;                           // RQ3 RQ1 RQ2 RQ20
          d.bsel = p.bsel;                           // RQ3 RQ20
        end
        if (q.strap_done && !p.cs_n) begin           // RQ4
          if (!p.rd_n) begin                         // RQ14 RQ17
            d.state = ghap_pkg::GHAP_RD_MEM;
            d.req   = 1'b1;
            d.we    = 1'b0;
            d.dstb  = 1'b0;                          // RQ6
          end else if (!p.wr_n) begin                // RQ15
            d.state = ghap_pkg::GHAP_WR_ACC;
            d.ready = 1'b1;                          // RQ12
          end
        end
      end
      ghap_pkg::GHAP_RD_MEM: begin
        if (i_acc_done || abort) begin
          d.state = ghap_pkg::GHAP_RD_RDY;
          d.req   = 1'b0;
          d.dstb  = ghap_pkg::STB_IDLE;              // RQ6
          d.ready = 1'b1;                            // RQ12 RQ7
        end
      end
      ghap_pkg::GHAP_RD_RDY: begin
        // Ready holds until the strobe is seen high, so the host can read the latch at leisure
        if (p.rd_n) begin                            // RQ13
          d.state = ghap_pkg::GHAP_IDLE;
          d.ready = 1'b0;                            // RQ12
        end
      end
      ghap_pkg::GHAP_WR_ACC: begin
        // Memory write waits for the strobe rising edge, when the latch is known to hold data
        if (p.wr_n && !q.wr_prev) begin              // RQ16
          d.state = ghap_pkg::GHAP_WR_MEM;
          d.ready = 1'b0;
          d.oe    = 1'b1;                            // RQ10 RQ11
          d.req   = 1'b1;
          d.we    = 1'b1;
        end
      end
      ghap_pkg::GHAP_WR_MEM: begin
        if (i_acc_done || abort) begin
          d.state = ghap_pkg::GHAP_IDLE;
          d.oe    = 1'b0;                            // RQ10
          d.req   = 1'b0;
          d.we    = 1'b0;
        end
      end
      default: begin
        d = CORE_RST;
      end
    endcase

    // Set beats clear: a fault in the clearing cycle is kept
    if (abort && (q.state == ghap_pkg::GHAP_RD_MEM || q.state == ghap_pkg::GHAP_WR_MEM)) begin
      d.fault = 1'b1;                                // RQ9
    end
    d.irq = i_irq_out_request_bit | (d.fault & i_fault_irq_en); // RQ8 RQ9
  end

  always_ff @(posedge i_sys_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      q <= CORE_RST;
    end else begin
      q <= d;                                        // RQ19
    end
  end

  assign o_host_ready_out    = q.ready;
  assign o_read_latch_strobe = q.dstb;
  assign o_write_latch_oe    = q.oe;
  assign o_host_irq_out      = q.irq;
  assign o_acc_req           = q.req;
  assign o_acc_we            = q.we;
  assign o_acc_addr          = q.addr;
  assign o_acc_bsel          = q.bsel;
  assign o_fault_flag        = q.fault;
  assign o_halted            = q.halted;
  assign o_self_boot         = q.self_boot;

endmodule : ghap_port

// ==== core/ghap_pkg.sv ====
// Constants, state codes and pin bundle types for the graphics host access port.
// Assumes a single 25 MHz system clock that also times the local output clocks.
package ghap_pkg;

  localparam int ADDR_W = 27;
  localparam int BSEL_W = 4;

  // Synchroniser depth seen by the reset strap sampler
  localparam logic [1:0] STRAP_WAIT = 2'h2;

  localparam logic [ADDR_W-1:0] ADDR_RST = 27'h0000000;
  localparam logic [BSEL_W-1:0] BSEL_RST = 4'h0;
  localparam logic              STB_IDLE = 1'b1;

  typedef enum logic [2:0] {
    GHAP_IDLE   = 3'b000,
    GHAP_RD_MEM = 3'b001,
    GHAP_RD_RDY = 3'b010,
    GHAP_WR_ACC = 3'b011,
    GHAP_WR_MEM = 3'b100
  } ghap_state_t;

  typedef struct packed {
    logic              cs_n;
    logic              rd_n;
    logic              wr_n;
    logic [ADDR_W-1:0] addr;
    logic [BSEL_W-1:0] bsel;
  } ghap_pins_t;

  localparam ghap_pins_t PINS_RST = '{cs_n: STB_IDLE, rd_n: STB_IDLE, wr_n: STB_IDLE,
                                      addr: ADDR_RST, bsel: BSEL_RST};

endpackage : ghap_pkg

// ==== core/ghap_pin_if.sv ====
// Carrier for the synchronised host pins between the synchroniser and the port core.
// Assumes both ends run on the same system clock.
`timescale 1ns/1ps
interface ghap_pin_if;
  ghap_pkg::ghap_pins_t pins;
  modport src (output pins);
  modport dst (input  pins);
endinterface : ghap_pin_if

// ==== core/ghap_sync.sv ====
// Two-stage synchroniser for every host pin that enters the port.
// Assumes host pins are asynchronous to i_sys_clk; only stage two is read outside.
`timescale 1ns/1ps
module ghap_sync (
  input  wire logic                         i_sys_clk,
  input  wire logic                         i_rstn,
  input  wire logic                         i_host_select_n,
  input  wire logic                         i_host_read_n,
  input  wire logic                         i_host_write_n,
  input  wire logic [ghap_pkg::ADDR_W-1:0]  i_host_long_addr,
  input  wire logic [ghap_pkg::BSEL_W-1:0]  i_host_byte_sel,
  ghap_pin_if.src                           pin_out
);

  typedef struct packed {
    ghap_pkg::ghap_pins_t s1;
    ghap_pkg::ghap_pins_t s2;
  } ghap_sync_t;

  ghap_sync_t q;
  ghap_sync_t d;

  always_comb begin
    d         = q;
    d.s1.cs_n = i_host_select_n;
    d.s1.rd_n = i_host_read_n;
    d.s1.wr_n = i_host_write_n;
    d.s1.addr = i_host_long_addr;
    d.s1.bsel = i_host_byte_sel;
    d.s2      = q.s1;
  end

  always_ff @(posedge i_sys_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      q <= '{s1: ghap_pkg::PINS_RST, s2: ghap_pkg::PINS_RST};
    end else begin
      q <= d;
    end
  end

  assign pin_out.pins = q.s2;

endmodule : ghap_sync

// ==== sim/ghap_port_properties.sv ====
// Checker for the host access port; sees only the top module ports.
// Assumes one clock domain and the async active-low reset.
`timescale 1ns/1ps
module ghap_port_properties (
  input wire logic                        i_sys_clk,
  input wire logic                        i_rstn,
  input wire logic                        i_host_select_n,
  input wire logic                        i_host_write_n,
  input wire logic                        i_acc_done,
  input wire logic                        i_bus_fault_in,
  input wire logic                        i_retry_in,
  input wire logic                        i_irq_out_request_bit,
  input wire logic                        i_halt_clear,
  input wire logic                        o_host_ready_out,
  input wire logic                        o_read_latch_strobe,
  input wire logic                        o_write_latch_oe,
  input wire logic                        o_host_irq_out,
  input wire logic                        o_acc_req,
  input wire logic                        o_acc_we,
  input wire logic [ghap_pkg::ADDR_W-1:0] o_acc_addr,
  input wire logic [ghap_pkg::BSEL_W-1:0] o_acc_bsel,
  input wire logic                        o_fault_flag,
  input wire logic                        o_halted,
  input wire logic                        o_self_boot
);
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (!i_rstn);
  chk_strobe_fall_req: assert property ($fell(o_read_latch_strobe) |-> o_acc_req && !o_acc_we)
    else $error("read strobe fell without a read access");
  chk_read_done: assert property (o_acc_req && !o_acc_we && i_acc_done
    |=> $rose(o_read_latch_strobe) && o_host_ready_out && !o_acc_req) else $error("read end wrong");
  chk_oe_write: assert property (o_write_latch_oe |-> o_acc_req && o_acc_we && !o_host_ready_out)
    else $error("latch enable outside a write");
  chk_oe_end: assert property (o_write_latch_oe && (i_acc_done || i_bus_fault_in || i_retry_in)
    |=> !o_write_latch_oe && !o_acc_req) else $error("latch enable not dropped");
  chk_oe_after_rise: assert property ($rose(o_write_latch_oe)
    |-> $past(o_host_ready_out) && $past(i_host_write_n, 2)) else $error("write began before strobe rise");
  chk_ready_idle: assert property (!(o_host_ready_out && o_acc_req)) else $error("ready while busy");
  chk_fault_sets: assert property (o_acc_req && (i_bus_fault_in || i_retry_in)
    |=> o_fault_flag && !o_acc_req) else $error("fault did not end access");
  chk_irq_follow: assert property (!o_fault_flag && !$past(o_fault_flag) && $past(i_rstn)
    |-> o_host_irq_out == $past(i_irq_out_request_bit)) else $error("interrupt does not follow bit");
  chk_addr_hold: assert property (o_acc_req && $past(o_acc_req)
    |-> $stable(o_acc_addr) && $stable(o_acc_bsel)) else $error("address moved in access");
  chk_read_sel: assert property ($rose(o_acc_req) && !o_acc_we |-> !$past(i_host_select_n, 2))
    else $error("read taken without select");
  chk_halt_clear: assert property (o_halted && i_halt_clear |=> !o_halted) else $error("halt kept");
  chk_mode_excl: assert property (!(o_halted && o_self_boot)) else $error("both boot modes");
endmodule : ghap_port_properties

bind ghap_port ghap_port_properties i_ghap_port_properties (.i_sys_clk, .i_rstn, .i_host_select_n,
  .i_host_write_n, .i_acc_done, .i_bus_fault_in, .i_retry_in, .i_irq_out_request_bit, .i_halt_clear,
  .o_host_ready_out, .o_read_latch_strobe, .o_write_latch_oe, .o_host_irq_out, .o_acc_req, .o_acc_we,
  .o_acc_addr, .o_acc_bsel, .o_fault_flag, .o_halted, .o_self_boot);

// ==== sim/ghap_host_model.sv ====
// Host processor model: select, address, byte selects and strobes.
// Assumes one access() call at a time from the bench main thread.
`timescale 1ns/1ps
module ghap_host_model (
  input  wire logic                        i_sys_clk,
  input  wire logic                        i_ready,
  input  wire logic                        i_oe,
  output logic                             o_sel_n,
  output logic                             o_rd_n,
  output logic                             o_wr_n,
  output logic [ghap_pkg::ADDR_W-1:0]      o_addr,
  output logic [ghap_pkg::BSEL_W-1:0]      o_bsel
);
  initial begin
    {o_sel_n, o_rd_n, o_wr_n} = 3'h7;
    o_addr = '0;
    o_bsel = 4'h0;
  end
  task automatic strap(input logic v);
    o_sel_n <= v;
  endtask : strap
  // Raw strobe levels, used with select high to try accesses the port must refuse
  task automatic strobe(input logic rd_n, input logic wr_n);
    o_rd_n <= rd_n;
    o_wr_n <= wr_n;
  endtask : strobe
  // Unbounded wait; a hang is caught by the bench watchdog
  task automatic wait_rdy(input logic v);
    do @(posedge i_sys_clk); while (i_ready !== v);
  endtask : wait_rdy
  task automatic access(input logic we, input logic [ghap_pkg::ADDR_W-1:0] a, input logic [3:0] b);
    @(posedge i_sys_clk);
    o_sel_n <= 1'b0;
    o_addr  <= a;
    o_bsel  <= b;
    repeat (3) @(posedge i_sys_clk);
    if (we) o_wr_n <= 1'b0; else o_rd_n <= 1'b0;
    wait_rdy(1'b1);
    o_rd_n <= 1'b1;
    o_wr_n <= 1'b1;
    wait_rdy(1'b0);
    do @(posedge i_sys_clk); while (i_oe !== 1'b0);
    o_sel_n <= 1'b1;
    o_addr  <= ~a; // Released lines must not keep the old value
    o_bsel  <= ~b;
    repeat (3) @(posedge i_sys_clk);
  endtask : access
endmodule : ghap_host_model

// ==== sim/test_graphics_host_access_port.sv ====
// Self-checking bench: random host reads and writes, faults, boot straps.
// Assumes package, design, checker and host model compiled first.
`timescale 1ns/1ps
module test_graphics_host_access_port;
  logic i_sys_clk, i_rstn, i_host_select_n, i_host_read_n, i_host_write_n, i_acc_done, i_bus_fault_in;
  logic i_retry_in, i_irq_out_request_bit, i_fault_irq_en, i_fault_clr, i_halt_clear, go, inj, exp_we;
  logic o_host_ready_out, o_read_latch_strobe, o_write_latch_oe, o_host_irq_out, o_acc_req, o_acc_we;
  logic o_fault_flag, o_halted, o_self_boot;
  logic [ghap_pkg::ADDR_W-1:0] i_host_long_addr, o_acc_addr, exp_addr;
  logic [ghap_pkg::BSEL_W-1:0] i_host_byte_sel, o_acc_bsel, exp_bsel;
  int errors, checked;
  ghap_port i_ghap_port (.i_sys_clk, .i_rstn, .i_host_long_addr, .i_host_byte_sel, .i_host_select_n,
    .i_host_read_n, .i_host_write_n, .i_acc_done, .i_bus_fault_in, .i_retry_in, .i_irq_out_request_bit,
    .i_fault_irq_en, .i_fault_clr, .i_halt_clear, .o_host_ready_out, .o_read_latch_strobe,
    .o_write_latch_oe, .o_host_irq_out, .o_acc_req, .o_acc_we, .o_acc_addr, .o_acc_bsel, .o_fault_flag,
    .o_halted, .o_self_boot);
  ghap_host_model i_ghap_host_model (.i_sys_clk, .i_ready(o_host_ready_out), .i_oe(o_write_latch_oe),
    .o_sel_n(i_host_select_n), .o_rd_n(i_host_read_n), .o_wr_n(i_host_write_n),
    .o_addr(i_host_long_addr), .o_bsel(i_host_byte_sel));
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      errors++;
      $display("MISMATCH %s expected %h seen %h", name, exp, seen);
    end
  endtask : check
  task automatic report_and_stop;
    if (errors == 0 && checked > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : report_and_stop
  function automatic logic exp_irq(input logic r, input logic f, input logic e);
    return r | (f & e);
  endfunction : exp_irq
  initial begin
    i_sys_clk = 1'b0;
    forever #20 i_sys_clk = ~i_sys_clk;
  end
  // Engine stand-in: answers after a random wait, or faults when told to
  always @(posedge i_sys_clk) begin
    go = o_acc_req && !i_acc_done && !i_bus_fault_in && !i_retry_in && ($urandom % 3 == 0);
    if (go) begin
      check("acc_we", o_acc_we, exp_we);
      check("acc_addr", o_acc_addr, exp_addr);
      check("acc_bsel", o_acc_bsel, exp_bsel);
    end
    i_acc_done     <= go && !inj;
    i_bus_fault_in <= go && inj && exp_addr[0];
    i_retry_in     <= go && inj && !exp_addr[0];
  end
  initial begin
    repeat (6000) @(posedge i_sys_clk);
    errors++;
    report_and_stop();
  end
  initial begin
    void'($urandom(30));
    {i_acc_done, i_bus_fault_in, i_retry_in, i_fault_clr, i_halt_clear, i_fault_irq_en} = 6'h00;
    {i_irq_out_request_bit, inj, exp_we, i_rstn} = 4'h0;
    exp_addr = '0;
    exp_bsel = 4'h0;
    repeat (2) @(posedge i_sys_clk);
    i_rstn <= 1'b1;
    repeat (5) @(posedge i_sys_clk);
    check("halted", o_halted, 1);
    check("self_boot", o_self_boot, 0);
    i_halt_clear <= 1'b1;
    i_irq_out_request_bit <= 1'b1;
    @(posedge i_sys_clk);
    i_halt_clear <= 1'b0;
    repeat (2) @(posedge i_sys_clk);
    check("halted", o_halted, 0);
    check("irq", o_host_irq_out, 1);
    i_irq_out_request_bit <= 1'b0;
    i_rstn <= 1'b0;
    i_ghap_host_model.strap(1'b0);
    repeat (2) @(posedge i_sys_clk);
    i_rstn <= 1'b1;
    repeat (5) @(posedge i_sys_clk);
    check("self_boot", o_self_boot, 1);
    check("halted", o_halted, 0);
    i_ghap_host_model.strap(1'b1);
    repeat (3) @(posedge i_sys_clk);
    for (int s = 0; s < 2; s++) begin
      i_ghap_host_model.strobe(s[0], !s[0]);
      repeat (6) @(posedge i_sys_clk);
      check("stray_req", o_acc_req, 0);
      check("stray_ready", o_host_ready_out, 0);
      i_ghap_host_model.strobe(1'b1, 1'b1);
      repeat (4) @(posedge i_sys_clk);
    end
    for (int n = 0; n < 40; n++) begin
      exp_we   = (n < 2) ? n[0] : 1'($urandom);
      exp_addr = (n == 0) ? '1 : (n == 1) ? '0 : 27'($urandom);
      exp_bsel = (n == 0) ? 4'hf : (n == 1) ? 4'h1 : 4'($urandom);
      inj = n > 2 && $urandom % 4 == 0;
      i_fault_irq_en <= 1'($urandom);
      i_ghap_host_model.access(exp_we, exp_addr, exp_bsel);
      check("fault", o_fault_flag, inj);
      check("irq", o_host_irq_out, exp_irq(i_irq_out_request_bit, inj, i_fault_irq_en));
      i_fault_clr <= 1'b1;
      @(posedge i_sys_clk);
      i_fault_clr <= 1'b0;
    end
    report_and_stop();
  end
endmodule : test_graphics_host_access_port
